// ### verilog/page_addr_pkg.sv
/*
  Constants for the paged data-space address generator.
  Assumes a 16-bit data address and 10-bit page select registers.
*/
`default_nettype none
package page_addr_pkg;
  localparam int          PAGE_W          = 10;
  localparam int          EA_W            = 16;
  localparam int          EA_TOP          = 15;
  localparam logic [9:0]  PAGE_RESET      = 10'h001;
  localparam logic [9:0]  PAGE_ZERO       = 10'h000;
  localparam logic [9:0]  PAGE_EDS_ONE    = 10'h001;
  localparam logic [9:0]  PAGE_EDS_LAST   = 10'h1FF;
  localparam logic [9:0]  PAGE_PSV_FIRST  = 10'h200;
  localparam logic [9:0]  PAGE_LSW_LAST   = 10'h2FF;
  localparam logic [9:0]  PAGE_MSB_FIRST  = 10'h300;
  localparam logic [9:0]  PAGE_MSB_LAST   = 10'h3FF;

  typedef enum logic [2:0] {
    MODE_PLAIN    = 3'h0,
    MODE_PRE_POST = 3'h1,
    MODE_REG_OFS  = 3'h2,
    MODE_MODULO   = 3'h3,
    MODE_BIT_REV  = 3'h4
  } addr_mode_t;
endpackage : page_addr_pkg
`default_nettype wire

// ### verilog/page_addr_gen.sv
/*
  Paged effective-address generator: page select registers, page
  overflow and underflow handling, and address error detection.
  Assumes the core presents one access per cycle with the unmodified
  and modified addresses already computed, and a carry/borrow flag.
*/
`timescale 1ns/1ps
`default_nettype none
// Function
// - Reads use the read page register and writes the write page register.
// - A plain-mode page crossing inside a paged window clears address bit 15.
// - Crossing is seen for any paged address with a carry or borrow, in any mode.
// - An overflow normally increments the active page and sets bit 15.
// - An underflow normally decrements the active page and sets bit 15.
// - Offset, modulo and bit-reversed crossings set bit 15, keep the page.
// - Overflows at the edge pages, and read underflows there, keep the page and clear bit 15.
// - Read pages 0x2FF and 0x300 step across to each other, bit 15 set.
// - A paged access with page zero raises an address error.
// - A paged write into program space raises an address error.
module page_addr_gen
  import page_addr_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              page_wr_en,
  input  wire logic              page_wr_sel,
  input  wire logic [PAGE_W-1:0] page_wr_data,
  input  wire logic              acc_valid,
  input  wire logic              acc_write,
  input  wire addr_mode_t        acc_mode,
  input  wire logic [EA_W-1:0]   ea_before,
  input  wire logic [EA_W-1:0]   ea_modified,
  input  wire logic              ea_carry,
  input  wire logic              ea_borrow,
  output logic [EA_W-1:0]        ea_out,
  output logic [PAGE_W-1:0]      page_out,
  output logic                   ea_paged,
  output logic                   addr_error,
  output logic [PAGE_W-1:0]      read_page_select,
  output logic [PAGE_W-1:0]      write_page_select
);
  logic [PAGE_W-1:0] rpage_q, rpage_d, wpage_q, wpage_d;
  logic [PAGE_W-1:0] act_page, new_page;
  logic [EA_W-1:0]   ea_q, ea_d;
  logic [PAGE_W-1:0] pg_q, pg_d;
  logic              paged_q, paged_d, err_q, err_d;
  logic              in_window, cross_mode, ovf, unf, wrap_mode, bit15;

  always_comb begin
    act_page   = acc_write ? wpage_q : rpage_q;
    in_window  = ea_before[EA_TOP];
    cross_mode = (acc_mode == MODE_PRE_POST);
    wrap_mode  = (acc_mode == MODE_REG_OFS) || (acc_mode == MODE_MODULO)
                 || (acc_mode == MODE_BIT_REV);
    ovf = in_window && ea_carry;
    unf = in_window && ea_borrow;
    new_page = act_page;
    bit15    = ea_modified[EA_TOP];
    if (in_window && (ovf || unf)) begin
      bit15 = 1'b0;
      if (wrap_mode) begin
        bit15 = 1'b1;
      end else if (cross_mode && ovf) begin
        if (act_page == PAGE_EDS_LAST || act_page == PAGE_MSB_LAST) begin
          bit15 = 1'b0;
        end else if (!acc_write && act_page == PAGE_LSW_LAST) begin
          new_page = PAGE_MSB_FIRST;
          bit15    = 1'b1;
        end else begin
          new_page = act_page + 10'h001;
          bit15    = 1'b1;
        end
      end else if (cross_mode && unf) begin
        if (!acc_write && (act_page == PAGE_EDS_ONE
            || act_page == PAGE_PSV_FIRST)) begin
          bit15 = 1'b0;
        end else if (!acc_write && act_page == PAGE_MSB_FIRST) begin
          new_page = PAGE_LSW_LAST;
          bit15    = 1'b1;
        end else begin
          new_page = act_page - 10'h001;
          bit15    = 1'b1;
        end
      end
    end
    rpage_d = rpage_q;
    wpage_d = wpage_q;
    if (acc_valid && !acc_write) rpage_d = new_page;
    if (acc_valid && acc_write)  wpage_d = new_page;
    if (page_wr_en && !page_wr_sel) rpage_d = page_wr_data;
    if (page_wr_en && page_wr_sel)  wpage_d = page_wr_data;
    ea_d    = {bit15, ea_modified[EA_TOP-1:0]};
    pg_d    = bit15 ? new_page : PAGE_ZERO;
    paged_d = acc_valid && bit15;
    err_d   = acc_valid && in_window && ((act_page == PAGE_ZERO)
              || (acc_write && act_page >= PAGE_PSV_FIRST));
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rpage_q <= PAGE_RESET;
      wpage_q <= PAGE_RESET;
      ea_q    <= '0;
      pg_q    <= PAGE_ZERO;
      paged_q <= 1'b0;
      err_q   <= 1'b0;
    end else begin
      rpage_q <= rpage_d;
      wpage_q <= wpage_d;
      ea_q    <= ea_d;
      pg_q    <= pg_d;
      paged_q <= paged_d;
      err_q   <= err_d;
    end
  end

  assign ea_out            = ea_q;
  assign page_out          = pg_q;
  assign ea_paged          = paged_q;
  assign addr_error        = err_q;
  assign read_page_select  = rpage_q;
  assign write_page_select = wpage_q;

  zero_page_a: assert property (@(posedge clk) disable iff (rst)
    acc_valid && ea_before[EA_TOP] && !page_wr_en
    && (acc_write ? wpage_q : rpage_q) == PAGE_ZERO |=> addr_error)
    else $error("page zero access without error");
  ps_write_a: assert property (@(posedge clk) disable iff (rst)
    acc_valid && acc_write && ea_before[EA_TOP]
    && wpage_q >= PAGE_PSV_FIRST |=> addr_error)
    else $error("program space write without error");
  ovf_inc_a: assert property (@(posedge clk) disable iff (rst)
    acc_valid && !acc_write && !page_wr_en && ea_before[EA_TOP] && ea_carry
    && acc_mode == MODE_PRE_POST && rpage_q == 10'h005
    |=> rpage_q == 10'h006 && ea_out[EA_TOP])
    else $error("overflow did not advance read page");
  unf_dec_a: assert property (@(posedge clk) disable iff (rst)
    acc_valid && acc_write && !page_wr_en && ea_before[EA_TOP] && ea_borrow
    && acc_mode == MODE_PRE_POST && wpage_q == 10'h010
    |=> wpage_q == 10'h00F && ea_out[EA_TOP])
    else $error("underflow did not step write page back");
  wrap_keep_a: assert property (@(posedge clk) disable iff (rst)
    acc_valid && !page_wr_en && ea_before[EA_TOP] && (ea_carry || ea_borrow)
    && acc_mode == MODE_MODULO
    |=> $stable(rpage_q) && $stable(wpage_q) && ea_out[EA_TOP])
    else $error("wrap mode changed page");
  edge_keep_a: assert property (@(posedge clk) disable iff (rst)
    acc_valid && !acc_write && !page_wr_en && ea_before[EA_TOP] && ea_carry
    && acc_mode == MODE_PRE_POST && rpage_q == PAGE_EDS_LAST
    |=> rpage_q == PAGE_EDS_LAST && !ea_out[EA_TOP] && !ea_paged)
    else $error("edge overflow left window");
  lsw_msb_a: assert property (@(posedge clk) disable iff (rst)
    acc_valid && !acc_write && !page_wr_en && ea_before[EA_TOP] && ea_borrow
    && acc_mode == MODE_PRE_POST && rpage_q == PAGE_MSB_FIRST
    |=> rpage_q == PAGE_LSW_LAST && ea_out[EA_TOP])
    else $error("msb to lsw step failed");
  // Overflow out of the last low-word page lands on the first high page
  lsw_msb_up_a: assert property (@(posedge clk) disable iff (rst)
    acc_valid && !acc_write && !page_wr_en && ea_before[EA_TOP] && ea_carry
    && acc_mode == MODE_PRE_POST && rpage_q == PAGE_LSW_LAST
    |=> rpage_q == PAGE_MSB_FIRST && ea_out[EA_TOP])
    else $error("lsw to msb step failed");
  // General read underflow steps the read page back
  rd_unf_dec_a: assert property (@(posedge clk) disable iff (rst)
    acc_valid && !acc_write && !page_wr_en && ea_before[EA_TOP] && ea_borrow
    && acc_mode == MODE_PRE_POST && rpage_q == 10'h005
    |=> rpage_q == 10'h004 && ea_out[EA_TOP])
    else $error("underflow did not step read page back");
  // Top of program space does not wrap to page zero
  msb_edge_a: assert property (@(posedge clk) disable iff (rst)
    acc_valid && !acc_write && !page_wr_en && ea_before[EA_TOP] && ea_carry
    && acc_mode == MODE_PRE_POST && rpage_q == PAGE_MSB_LAST
    |=> rpage_q == PAGE_MSB_LAST && !ea_out[EA_TOP] && page_out == PAGE_ZERO)
    else $error("top page overflow left window");
  // Bottom of program space falls back to base space
  psv_edge_a: assert property (@(posedge clk) disable iff (rst)
    acc_valid && !acc_write && !page_wr_en && ea_before[EA_TOP] && ea_borrow
    && acc_mode == MODE_PRE_POST && rpage_q == PAGE_PSV_FIRST
    |=> rpage_q == PAGE_PSV_FIRST && !ea_out[EA_TOP])
    else $error("first program page underflow stayed paged");
  // A write access never disturbs the read page
  read_keep_a: assert property (@(posedge clk) disable iff (rst)
    acc_valid && acc_write && !page_wr_en
    |=> $stable(rpage_q))
    else $error("write access moved read page");
  // A read access never disturbs the write page
  write_keep_a: assert property (@(posedge clk) disable iff (rst)
    acc_valid && !acc_write && !page_wr_en
    |=> $stable(wpage_q))
    else $error("read access moved write page");
  // A page load takes effect whatever access runs beside it
  rd_load_a: assert property (@(posedge clk) disable iff (rst)
    page_wr_en && !page_wr_sel
    |=> rpage_q == $past(page_wr_data))
    else $error("read page load lost");
  wr_load_a: assert property (@(posedge clk) disable iff (rst)
    page_wr_en && page_wr_sel
    |=> wpage_q == $past(page_wr_data))
    else $error("write page load lost");
  // Without an access the status outputs stay quiet
  idle_quiet_a: assert property (@(posedge clk) disable iff (rst)
    !acc_valid
    |=> !addr_error && !ea_paged)
    else $error("status raised without access");
  // Reads through a nonzero page never trap
  rd_no_error_a: assert property (@(posedge clk) disable iff (rst)
    acc_valid && !acc_write && rpage_q != PAGE_ZERO
    |=> !addr_error)
    else $error("read raised address error");
  no_cross_a: assert property (@(posedge clk) disable iff (rst)
    acc_valid && !page_wr_en && !ea_before[EA_TOP]
    |=> $stable(rpage_q) && $stable(wpage_q))
    else $error("page changed outside window");
endmodule : page_addr_gen
`default_nettype wire

// ### bench/core_model.sv
/* Core model: presents one access with its modified address.
   Assumes issue is called at a falling edge of clk. */
`timescale 1ns/1ps
`default_nettype none
module core_model
  import page_addr_pkg::*;
(
  input  wire logic       clk,
  output logic            acc_valid,
  output logic            acc_write,
  output addr_mode_t      acc_mode,
  output logic [EA_W-1:0] ea_before,
  output logic [EA_W-1:0] ea_modified,
  output logic            ea_carry,
  output logic            ea_borrow
);
  initial {acc_valid, acc_write, ea_before, ea_modified} = '0;
  initial {ea_carry, ea_borrow} = '0;
  initial acc_mode = MODE_PLAIN;
  task automatic issue(input logic w, input addr_mode_t m,
                       input logic [15:0] b, input logic up);
    acc_valid = 1'h1;
    acc_write = w;
    acc_mode = m;
    ea_before = b;
    ea_modified = up ? b + 16'h0002 : b - 16'h0002; // Small steps
    ea_carry = up && (b[14:0] > 15'h7FFD);
    ea_borrow = !up && (b[14:0] < 15'h0002);
    @(negedge clk);
    acc_valid = 1'h0;
    // Idle lines show no stale value
    {ea_before, ea_modified} = ~{ea_before, ea_modified};
    {ea_carry, ea_borrow} = ~{ea_carry, ea_borrow};
  endtask : issue
endmodule : core_model
`default_nettype wire

// ### bench/paged_data_space_addressing_tb_top.sv
/* Bench for the page address generator: row table then hand cases.
   Assumes the core model in core_model.sv. */
`timescale 1ns/1ps
`default_nettype none
module paged_data_space_addressing_tb_top
  import page_addr_pkg::*;
;
  typedef struct packed {logic w; logic [2:0] m; logic [9:0] pg;
    logic [15:0] eb; logic up; logic [9:0] xp; logic x15, xer, ck;} row_t;
  localparam row_t ROWS[17] = '{
    '{0,1,10'h005,16'hFFFE,1,10'h006,1,0,1}, '{0,1,10'h005,16'h8000,0,10'h004,1,0,1},
    '{1,1,10'h005,16'hFFFE,1,10'h006,1,0,1}, '{0,2,10'h005,16'hFFFE,1,10'h005,1,0,1},
    '{0,3,10'h005,16'h8000,0,10'h005,1,0,1}, '{0,4,10'h005,16'hFFFE,1,10'h005,1,0,1},
    '{0,1,10'h1FF,16'hFFFE,1,10'h1FF,0,0,1}, '{0,1,10'h3FF,16'hFFFE,1,10'h3FF,0,0,1},
    '{0,1,10'h001,16'h8000,0,10'h001,0,0,1}, '{0,1,10'h200,16'h8000,0,10'h200,0,0,1},
    '{1,1,10'h1FF,16'hFFFE,1,10'h1FF,0,0,1}, '{0,1,10'h2FF,16'hFFFE,1,10'h300,1,0,1},
    '{0,1,10'h300,16'h8000,0,10'h2FF,1,0,1}, '{0,1,10'h005,16'h0000,0,10'h005,0,0,0},
    '{0,0,10'h000,16'h9000,1,10'h000,0,1,0}, '{1,0,10'h200,16'h9000,1,10'h200,0,1,0},
    '{1,1,10'h010,16'h8000,0,10'h00F,1,0,1}};
  logic clk = 1'h0, rst = 1'h1, page_wr_en = 1'h0, page_wr_sel = 1'h0;
  logic [9:0] page_wr_data = '0, rps, wps, page_out;
  logic acc_valid, acc_write, ea_carry, ea_borrow, ea_paged, addr_error;
  logic [15:0] ea_before, ea_modified, ea_out;
  addr_mode_t acc_mode;
  int error_cnt = 0, comparisons = 0, cyc = 0;
  always #4 clk = ~clk;
  core_model core_u (.clk(clk), .acc_valid(acc_valid), .acc_write(acc_write),
    .acc_mode(acc_mode), .ea_before(ea_before), .ea_modified(ea_modified),
    .ea_carry(ea_carry), .ea_borrow(ea_borrow));
  page_addr_gen dut_u (.clk(clk), .rst(rst), .page_wr_en(page_wr_en),
    .page_wr_sel(page_wr_sel), .page_wr_data(page_wr_data), .acc_valid(acc_valid),
    .acc_write(acc_write), .acc_mode(acc_mode), .ea_before(ea_before),
    .ea_modified(ea_modified), .ea_carry(ea_carry), .ea_borrow(ea_borrow),
    .ea_out(ea_out), .page_out(page_out), .ea_paged(ea_paged),
    .addr_error(addr_error), .read_page_select(rps), .write_page_select(wps));
  task automatic chk(input string n, input logic [15:0] s, e);
    comparisons++;
    if (s !== e) begin
      error_cnt++;
      $display("BAD %s exp %h saw %h", n, e, s);
    end
  endtask : chk
  task automatic report_and_stop();
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : report_and_stop
  always @(posedge clk) begin
    cyc++;
    if (cyc == 1000) begin
      error_cnt++;
      report_and_stop();
    end
  end
  initial begin
    repeat (10) @(negedge clk);
    rst = 1'h0;
    chk("rps_rst", rps, 10'h001);
    chk("wps_rst", wps, 10'h001);
    foreach (ROWS[i]) begin
      {page_wr_en, page_wr_sel, page_wr_data} = {1'h1, ROWS[i].w, ROWS[i].pg};
      @(negedge clk);
      page_wr_en = 1'h0;
      core_u.issue(ROWS[i].w, addr_mode_t'(ROWS[i].m), ROWS[i].eb, ROWS[i].up);
      chk("page", ROWS[i].w ? wps : rps, ROWS[i].xp);
      chk("err", addr_error, ROWS[i].xer);
      if (ROWS[i].ck) chk("ea15", ea_out[15], ROWS[i].x15);
    end
    {page_wr_en, page_wr_sel, page_wr_data} = {1'h1, 1'h0, 10'h050};
    core_u.issue(1'h0, MODE_PRE_POST, 16'hFFFE, 1'h1);
    page_wr_en = 1'h0;
    chk("load_wins", rps, 10'h050);
    rst = 1'h1;
    #1 chk("rps_rst2", rps, 10'h001);
    report_and_stop();
  end
endmodule : paged_data_space_addressing_tb_top
`default_nettype wire
